// ---- hdl/sbimc_pkg.sv ----
// constants and types shared by the serial block and its link engine
package sbimc_pkg;

	// default word width and buffer depth
	localparam int WORD_W = 8;
	localparam int BUF_DEPTH = 4;

	// register byte offsets on the peripheral bus
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CTRL2 = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;

	// control register field positions
	localparam int CTRL_ON = 15;
	localparam int CTRL_FRM = 14;
	localparam int CTRL_CKP = 6;
	localparam int CTRL_MST = 5;
	localparam int CTRL_REL = 4;
	localparam int CTRL_TXS = 2;
	localparam int CTRL_RXS = 0;

	// second control register field positions
	localparam int CTRL2_AUD = 7;

	// status register field positions
	localparam int STAT_BUSY = 0;
	localparam int STAT_TXF = 1;
	localparam int STAT_TXE = 2;
	localparam int STAT_RXF = 3;
	localparam int STAT_RXE = 4;
	localparam int STAT_TXC = 8;
	localparam int STAT_RXC = 16;

	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] CTRL2_RST = 32'h0000_0000;

	// interrupt condition selects, shared by transmit and receive
	typedef enum logic [1:0] {
		ISEL_LAST = 2'b00,
		ISEL_EDGE = 2'b01,
		ISEL_HALF = 2'b10,
		ISEL_LIMIT = 2'b11
	} sbimc_isel_t;

	// link engine states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LEAD = 2'b01,
		ST_TRAIL = 2'b10
	} sbimc_st_t;

endpackage : sbimc_pkg

// ---- hdl/sbimc_link_if.sv ----
// signals between the register side and the link-clock engine
`timescale 1ns/10ps
interface sbimc_link_if #(parameter int W = 8);
	logic start_tgl;
	logic [W-1:0] tx_word;
	logic master;
	logic cpol;
	logic sdi_rel;
	logic done_tgl;
	logic [W-1:0] rx_word;

	modport core (
		output start_tgl, tx_word, master, cpol, sdi_rel,
		input done_tgl, rx_word
	);
	modport engine (
		input start_tgl, tx_word, master, cpol, sdi_rel,
		output done_tgl, rx_word
	);
endinterface : sbimc_link_if

// ---- hdl/sbimc_engine.sv ----
// serial shift engine running on the link clock
`timescale 1ns/10ps
module sbimc_engine
	import sbimc_pkg::*;
#(
	parameter int WIDTH = WORD_W
)(
	input wire logic clk_link, // link clock
	input wire logic rstn, // reset from the system side, low active
	sbimc_link_if.engine lk, // words and settings from the core
	input wire logic sck_i, // serial clock pin in
	input wire logic sdi_i, // serial data pin in
	output logic sck_o, // serial clock pin out
	output logic sck_oe, // serial clock drive enable
	output logic sdo_o, // serial data out
	output logic sdo_oe // serial data drive enable
);

	localparam int NS = 7;
	localparam int BW = $clog2(WIDTH);
	localparam logic [BW-1:0] LAST_BIT = BW'(WIDTH - 1);

	logic [NS-1:0] in_v;
	logic [NS-1:0] s1_q;
	logic [NS-1:0] s2_q;
	logic [NS-1:0] s3_q;
	logic [NS-1:0] val_q;
	logic lrst_n;
	logic start_v, mst_v, cpol_v, rel_v, sck_v, sdi_v;
	logic sdi_eff;
	logic sck_prev_q;
	logic seen_q;
	logic lead, trail;
	sbimc_st_t st_q;
	logic [WIDTH-1:0] tx_sh_q;
	logic [WIDTH-1:0] rx_sh_q;
	logic [BW-1:0] bit_q;

	assign in_v = {rstn, lk.start_tgl, lk.master, lk.cpol, lk.sdi_rel,
		sck_i, sdi_i};

	// three-stage synchronisers, a change counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < NS; g++)
		begin : g_sync
			always_ff @(posedge clk_link)
			begin
				s1_q[g] <= in_v[g];
				s2_q[g] <= s1_q[g];
				s3_q[g] <= s2_q[g];
				if (s2_q[g] == s3_q[g])
					val_q[g] <= s3_q[g];
			end
		end
	endgenerate

	assign {lrst_n, start_v, mst_v, cpol_v, rel_v, sck_v, sdi_v} = val_q;

	// released input pin reads as zero
	assign sdi_eff = rel_v ? 1'b0 : sdi_v; // see RULE2

	// edges of the external clock, polarity aware
	assign lead = (sck_v != sck_prev_q) && (sck_v != cpol_v); // see RULE9
	assign trail = (sck_v != sck_prev_q) && (sck_v == cpol_v);

	// previous external clock level
	always_ff @(posedge clk_link)
	begin
		if (!lrst_n)
			sck_prev_q <= 1'b0;
		else
			sck_prev_q <= sck_v;
	end

	// word sequencer: master makes the clock, slave follows it
	always_ff @(posedge clk_link)
	begin
		if (!lrst_n)
		begin
			st_q <= ST_IDLE;
			seen_q <= 1'b0;
			tx_sh_q <= '0;
			rx_sh_q <= '0;
			bit_q <= '0;
			sck_o <= 1'b0;
			sck_oe <= 1'b0;
			sdo_o <= 1'b0;
			sdo_oe <= 1'b0;
			lk.done_tgl <= 1'b0;
			lk.rx_word <= '0;
		end
		else
		begin
			sck_oe <= mst_v; // see RULE1
			unique case (st_q)
				ST_IDLE:
				begin
					sck_o <= cpol_v; // see RULE9
					if (start_v != seen_q)
					begin
						seen_q <= start_v;
						tx_sh_q <= lk.tx_word;
						sdo_o <= lk.tx_word[WIDTH-1];
						sdo_oe <= 1'b1;
						bit_q <= '0;
						st_q <= ST_LEAD;
					end
				end
				ST_LEAD:
				begin
					if (mst_v || lead) // see RULE1
					begin
						if (mst_v)
							sck_o <= ~cpol_v;
						rx_sh_q <= {rx_sh_q[WIDTH-2:0], sdi_eff};
						st_q <= ST_TRAIL;
					end
				end
				ST_TRAIL:
				begin
					if (mst_v || trail) // see RULE1
					begin
						if (mst_v)
							sck_o <= cpol_v;
						if (bit_q == LAST_BIT)
						begin
							lk.rx_word <= rx_sh_q;
							lk.done_tgl <= ~lk.done_tgl;
							sdo_oe <= 1'b0;
							st_q <= ST_IDLE;
						end
						else
						begin
							tx_sh_q <= {tx_sh_q[WIDTH-2:0], 1'b0};
							sdo_o <= tx_sh_q[WIDTH-2];
							bit_q <= bit_q + 1'b1;
							st_q <= ST_LEAD;
						end
					end
				end
				default:
					st_q <= ST_IDLE;
			endcase
		end
	end

endmodule : sbimc_engine

// ---- hdl/sbimc_top.sv ----
// serial block with buffers, selectable interrupt conditions and bus slave
//
// What this block does
// (RULE1) Master select 1 drives the serial clock; 0 follows an outside one.
// (RULE2) Input release 1 leaves the data input pin to the port; 0 claims it.
// (RULE3) Tx select 11 asks while a slot is free, 10 while half or more are.
// (RULE4) Tx select 01 asks when empty, 00 also waits for the last shift out.
// (RULE5) Rx select 11 asks when full, 10 when half or more is filled.
// (RULE6) Rx select 01 asks while a word waits, 00 once a read empties it.
// (RULE7) Restricted bits take writes only while the module is off.
// (RULE8) In framed mode the marked bit is unused and software keeps it zero.
// (RULE9) In audio mode the clock polarity acts as one, whatever is stored.
// (RULE10) At a 1:1 ratio software skips registers the cycle after switch-off.
// (RULE11) Audio enable set selects codec operation, clear leaves it out.
// (RULE12) Both requests are re-evaluated each cycle and shown while true and the module is on.
`timescale 1ns/10ps
module sbimc_top
	import sbimc_pkg::*;
#(
	parameter int WIDTH = WORD_W,
	parameter int DEPTH = BUF_DEPTH
)(
	input wire logic clk_sys, // system clock
	input wire logic rstn, // synchronous reset, low active
	input wire logic clk_link, // link clock
	input wire logic psel, // bus select
	input wire logic penable, // bus access phase
	input wire logic pwrite, // bus write
	input wire logic [7:0] paddr, // bus byte address
	input wire logic [31:0] pwdata, // bus write data
	output logic [31:0] prdata, // bus read data
	output logic pready, // bus ready
	output logic pslverr, // bus error for unmapped address
	input wire logic sck_i, // serial clock pin in
	output logic sck_o, // serial clock pin out
	output logic sck_oe, // serial clock drive enable
	input wire logic sdi_i, // serial data pin in
	output logic sdo_o, // serial data out
	output logic sdo_oe, // serial data drive enable
	output logic sdi_own, // serial input pin owned by this block
	output logic tx_irq, // transmit interrupt request
	output logic rx_irq // receive interrupt request
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam logic [CW-1:0] FULL_N = CW'(DEPTH);
	localparam logic [CW-1:0] HALF_N = CW'(DEPTH / 2);
	localparam logic [CW-1:0] ONE_N = CW'(1);

	sbimc_link_if #(.W(WIDTH)) lk ();

	// control fields
	logic on_q, frm_q, ckp_q, mst_q, rel_q, aud_q;
	sbimc_isel_t txsel_q;
	sbimc_isel_t rxsel_q;

	// bus slave state
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic setup, wr_en, rd_en;

	// buffers
	logic [WIDTH-1:0] tx_mem [DEPTH];
	logic [WIDTH-1:0] rx_mem [DEPTH];
	logic [AW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
	logic [CW-1:0] tx_cnt_q, rx_cnt_q;
	logic tx_push, tx_pop, rx_push, rx_pop;
	logic tx_full, rx_full;

	// transfer handshake
	logic busy_q, start_q, launch;
	logic [WIDTH-1:0] tx_word_q;
	logic cpol_q;
	logic [2:0] dsync_q;
	logic done_v_q, done_seen_q, done_evt;
	logic rx_drain_q;
	logic tx_irq_q, rx_irq_q, sdi_own_q;

	// address decode for mapped registers
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == OFS_CTRL) || (a == OFS_CTRL2) ||
			(a == OFS_DATA) || (a == OFS_STAT);
	endfunction : is_mapped

	// transmit request condition
	function automatic logic tx_cond(input sbimc_isel_t s,
		input logic [CW-1:0] n, input logic busy);
		unique case (s)
			ISEL_LIMIT: tx_cond = (n < FULL_N); // see RULE3
			ISEL_HALF: tx_cond = ((FULL_N - n) >= HALF_N); // see RULE3
			ISEL_EDGE: tx_cond = (n == '0); // see RULE4
			ISEL_LAST: tx_cond = (n == '0) && !busy; // see RULE4
		endcase
	endfunction : tx_cond

	// receive request condition
	function automatic logic rx_cond(input sbimc_isel_t s,
		input logic [CW-1:0] n, input logic drained);
		unique case (s)
			ISEL_LIMIT: rx_cond = (n == FULL_N); // see RULE5
			ISEL_HALF: rx_cond = (n >= HALF_N); // see RULE5
			ISEL_EDGE: rx_cond = (n != '0); // see RULE6
			ISEL_LAST: rx_cond = drained; // see RULE6
		endcase
	endfunction : rx_cond

	// bus phase decode
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;
	assign rd_en = psel & penable & pready_q & ~pwrite & ~pslverr_q;

	assign tx_full = (tx_cnt_q == FULL_N);
	assign rx_full = (rx_cnt_q == FULL_N);
	assign tx_push = wr_en && (paddr == OFS_DATA) && !tx_full;
	assign rx_pop = rd_en && (paddr == OFS_DATA) && (rx_cnt_q != '0);
	assign rx_push = done_evt && !rx_full;

	// audio mode keeps words flowing, zeros when nothing is queued
	assign launch = on_q && !busy_q && ((tx_cnt_q != '0) || aud_q); // see RULE11
	assign tx_pop = launch && (tx_cnt_q != '0);

	// bus answer: ready and error in the access phase, data latched at setup
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			pready_q <= setup;
			pslverr_q <= setup && !is_mapped(paddr);
			if (setup && !pwrite)
			begin
				unique case (paddr)
					OFS_CTRL:
						prdata_q <= {16'h0000, on_q, frm_q, 7'h00, ckp_q,
							mst_q, rel_q, txsel_q, rxsel_q};
					OFS_CTRL2:
						prdata_q <= {24'h00_0000, aud_q, 7'h00};
					OFS_DATA:
						prdata_q <= 32'(rx_mem[rx_rp_q]);
					OFS_STAT:
						prdata_q <= {8'h00, 8'(rx_cnt_q), 8'(tx_cnt_q),
							3'h0, (rx_cnt_q == '0), rx_full,
							(tx_cnt_q == '0), tx_full, busy_q};
					default:
						prdata_q <= 32'h0000_0000;
				endcase
			end
			else
				prdata_q <= 32'h0000_0000;
		end
	end

	// control register writes, restricted bits locked while on
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			on_q <= CTRL_RST[CTRL_ON];
			frm_q <= CTRL_RST[CTRL_FRM];
			ckp_q <= CTRL_RST[CTRL_CKP];
			mst_q <= CTRL_RST[CTRL_MST];
			rel_q <= CTRL_RST[CTRL_REL];
			txsel_q <= sbimc_isel_t'(CTRL_RST[CTRL_TXS +: 2]);
			rxsel_q <= sbimc_isel_t'(CTRL_RST[CTRL_RXS +: 2]);
			aud_q <= CTRL2_RST[CTRL2_AUD];
		end
		else if (wr_en && (paddr == OFS_CTRL))
		begin
			on_q <= pwdata[CTRL_ON];
			frm_q <= pwdata[CTRL_FRM];
			rel_q <= pwdata[CTRL_REL];
			txsel_q <= sbimc_isel_t'(pwdata[CTRL_TXS +: 2]);
			rxsel_q <= sbimc_isel_t'(pwdata[CTRL_RXS +: 2]);
			if (!on_q)
			begin
				ckp_q <= pwdata[CTRL_CKP]; // see RULE7
				mst_q <= pwdata[CTRL_MST]; // see RULE7
			end
		end
		else if (wr_en && (paddr == OFS_CTRL2) && !on_q)
			aud_q <= pwdata[CTRL2_AUD]; // see RULE7
	end

	// transmit buffer storage
	always_ff @(posedge clk_sys)
	begin
		if (tx_push)
			tx_mem[tx_wp_q] <= pwdata[WIDTH-1:0];
	end

	// transmit buffer pointers and count
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			tx_wp_q <= '0;
			tx_rp_q <= '0;
			tx_cnt_q <= '0;
		end
		else
		begin
			if (tx_push)
				tx_wp_q <= tx_wp_q + 1'b1;
			if (tx_pop)
				tx_rp_q <= tx_rp_q + 1'b1;
			if (tx_push && !tx_pop)
				tx_cnt_q <= tx_cnt_q + ONE_N;
			else if (tx_pop && !tx_push)
				tx_cnt_q <= tx_cnt_q - ONE_N;
		end
	end

	// receive buffer storage, words beyond full are dropped
	always_ff @(posedge clk_sys)
	begin
		if (rx_push)
			rx_mem[rx_wp_q] <= lk.rx_word;
	end

	// receive buffer pointers and count
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			rx_wp_q <= '0;
			rx_rp_q <= '0;
			rx_cnt_q <= '0;
		end
		else
		begin
			if (rx_push)
				rx_wp_q <= rx_wp_q + 1'b1;
			if (rx_pop)
				rx_rp_q <= rx_rp_q + 1'b1;
			if (rx_push && !rx_pop)
				rx_cnt_q <= rx_cnt_q + ONE_N;
			else if (rx_pop && !rx_push)
				rx_cnt_q <= rx_cnt_q - ONE_N;
		end
	end

	// drained flag: set by the read that empties, cleared by a new word
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			rx_drain_q <= 1'b0;
		else if (rx_pop && (rx_cnt_q == ONE_N) && !rx_push)
			rx_drain_q <= 1'b1; // see RULE6
		else if (rx_push)
			rx_drain_q <= 1'b0;
	end

	// done toggle from the link side, three stages and agreement
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			dsync_q <= 3'h0;
			done_v_q <= 1'b0;
			done_seen_q <= 1'b0;
		end
		else
		begin
			dsync_q <= {dsync_q[1:0], lk.done_tgl};
			if (dsync_q[1] == dsync_q[2])
				done_v_q <= dsync_q[2];
			if (done_evt)
				done_seen_q <= done_v_q;
		end
	end

	assign done_evt = (done_v_q != done_seen_q);

	// word launch toward the link engine
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			busy_q <= 1'b0;
			start_q <= 1'b0;
			tx_word_q <= '0;
		end
		else if (launch)
		begin
			busy_q <= 1'b1;
			start_q <= ~start_q;
			tx_word_q <= (tx_cnt_q != '0) ? tx_mem[tx_rp_q] : '0;
		end
		else if (done_evt)
			busy_q <= 1'b0;
	end

	// effective polarity and pin ownership
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			cpol_q <= 1'b0;
			sdi_own_q <= 1'b0;
		end
		else
		begin
			cpol_q <= ckp_q | aud_q; // see RULE9
			sdi_own_q <= on_q & ~rel_q; // see RULE2
		end
	end

	// interrupt requests, re-evaluated every cycle
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			tx_irq_q <= 1'b0;
			rx_irq_q <= 1'b0;
		end
		else
		begin
			tx_irq_q <= on_q && tx_cond(txsel_q, tx_cnt_q, busy_q); // see RULE12
			rx_irq_q <= on_q && rx_cond(rxsel_q, rx_cnt_q, rx_drain_q); // see RULE12
		end
	end

	// settings and words handed to the link side
	assign lk.start_tgl = start_q;
	assign lk.tx_word = tx_word_q;
	assign lk.master = mst_q; // see RULE1
	assign lk.cpol = cpol_q;
	assign lk.sdi_rel = rel_q; // see RULE2

	sbimc_engine #(.WIDTH(WIDTH)) u_sbimc_engine (
		.clk_link(clk_link),
		.rstn(rstn),
		.lk(lk),
		.sck_i(sck_i),
		.sdi_i(sdi_i),
		.sck_o(sck_o),
		.sck_oe(sck_oe),
		.sdo_o(sdo_o),
		.sdo_oe(sdo_oe)
	);

	// outputs straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign sdi_own = sdi_own_q;
	assign tx_irq = tx_irq_q;
	assign rx_irq = rx_irq_q;

endmodule : sbimc_top

// ---- verification/sbimc_checker.sv ----
// port assertions for the serial block
`timescale 1ns/10ps
module sbimc_checker
	import sbimc_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic clk_link, // link clock
	input wire logic rstn, // reset, low active
	input wire logic psel, // bus select
	input wire logic penable, // access phase
	input wire logic pwrite, // bus write
	input wire logic [7:0] paddr, // byte address
	input wire logic [31:0] pwdata, // write data
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // bus ready
	input wire logic pslverr, // bus error
	input wire logic sck_oe, // clock drive enable
	input wire logic sdo_oe, // data drive enable
	input wire logic sdi_own, // input pin owned
	input wire logic tx_irq, // transmit request
	input wire logic rx_irq // receive request
);
	logic en_q;
	logic mst_q;
	logic wr_ctrl;
	logic setup;
	assign wr_ctrl = psel && penable && pready && pwrite && paddr == OFS_CTRL;
	assign setup = psel && !penable;
	// shadow of enable and the restricted master select
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			en_q <= 1'b0;
			mst_q <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			en_q <= pwdata[CTRL_ON];
			if (!en_q)
				mst_q <= pwdata[CTRL_MST];
		end
	end
	// bus side on the system clock, pin drives on the link clock
	ready_next_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		setup |=> pready)
		else $error("no ready after setup");
	ready_single_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		pready |=> !pready)
		else $error("ready held too long");
	err_unmapped_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		setup && paddr > OFS_STAT |=> pslverr)
		else $error("no error on unmapped address");
	err_mapped_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		setup && paddr <= OFS_STAT && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("error on mapped address");
	rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	pin_master_a: assert property (@(posedge clk_link)
		disable iff (!rstn) $changed(mst_q) |-> ##[1:8] sck_oe == mst_q)
		else $error("clock drive not following master select");
	mst_locked_a: assert property (@(posedge clk_link)
		disable iff (!rstn) $changed(sck_oe) |-> sck_oe == mst_q)
		else $error("clock drive changed by ignored write");
	own_pin_a: assert property (@(posedge clk_sys)
		disable iff (!rstn) wr_ctrl |-> ##2 sdi_own ==
		($past(pwdata[CTRL_ON], 2) && !$past(pwdata[CTRL_REL], 2)))
		else $error("input pin ownership wrong");
	irq_off_a: assert property (@(posedge clk_sys)
		disable iff (!rstn) !en_q && !$past(en_q) |-> !tx_irq && !rx_irq)
		else $error("request while disabled");
	word_hold_a: assert property (@(posedge clk_link)
		disable iff (!rstn) $rose(sdo_oe) |-> sdo_oe [*8])
		else $error("data drive dropped inside a word");
endmodule : sbimc_checker
bind sbimc_top sbimc_checker u_sbimc_checker (
	.clk_sys(clk_sys), .clk_link(clk_link), .rstn(rstn), .psel(psel),
	.penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sck_oe(sck_oe), .sdo_oe(sdo_oe),
	.sdi_own(sdi_own), .tx_irq(tx_irq), .rx_irq(rx_irq)
);

// ---- verification/sbimc_partner.sv ----
// far-side serial device: clocks frames in and watches data out
`timescale 1ns/10ps
module sbimc_partner
#(
	parameter int W = 8
)(
	input wire logic cpol, // idle clock level
	input wire logic sck_o, // block clock out
	input wire logic sck_oe, // block drives clock
	input wire logic sdo_o, // block data out
	output logic sck_i, // clock to block
	output logic sdi_i, // data to block
	output logic [W-1:0] got // last bits seen
);
	logic line;
	// clock seen on the wire
	assign line = sck_oe ? sck_o : sck_i;
	initial
	begin
		sck_i = 1'b0;
		sdi_i = 1'b0;
		got = '0;
	end
	// sample data out on the edge leaving idle
	always @(line)
		if (line !== cpol)
			got = {got[W-2:0], sdo_o};
	// one frame, msb first, clock still outside it
	task automatic frame(input logic [W-1:0] w);
		for (int i = W - 1; i >= 0; i--)
		begin
			sdi_i = w[i];
			#300 sck_i = ~cpol;
			#300 sck_i = cpol;
		end
		sdi_i = ~w[0];
	endtask : frame
endmodule : sbimc_partner

// ---- verification/sbimc_top_tb.sv ----
// self-checking bench for the serial block
`timescale 1ns/10ps
module sbimc_top_tb;
	import sbimc_pkg::*;
	logic clk_sys = 1'b0;
	logic clk_link = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er;
	logic cpol = 1'b0;
	logic sck_i, sck_o, sck_oe, sdi_i, sdo_o, sdo_oe, sdi_own, tx_irq, rx_irq;
	logic [7:0] got;
	int err_count = 0;
	int total_checks = 0;
	logic [7:0] tw [6] = '{8'hA5, 8'h3C, 8'h96, 8'hC3, 8'h69, 8'hFF};
	logic [7:0] pw [4] = '{8'h81, 8'h42, 8'h24, 8'h18};
	always #20 clk_sys = ~clk_sys;
	always #15 clk_link = ~clk_link;
	sbimc_top u_sbimc_top (
		.clk_sys(clk_sys), .rstn(rstn), .clk_link(clk_link), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_i(sck_i),
		.sck_o(sck_o), .sck_oe(sck_oe), .sdi_i(sdi_i), .sdo_o(sdo_o),
		.sdo_oe(sdo_oe), .sdi_own(sdi_own), .tx_irq(tx_irq), .rx_irq(rx_irq)
	);
	sbimc_partner u_partner (
		.cpol(cpol), .sck_o(sck_o), .sck_oe(sck_oe), .sdo_o(sdo_o),
		.sck_i(sck_i), .sdi_i(sdi_i), .got(got)
	);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : wt
	// one bus transfer, held until ready is sampled
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge clk_sys);
		end
		if (n == 20)
			err_count++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdc
	// both requests under every select, framed mode kept off
	task automatic irq_tab(input logic [3:0] tx_e, input logic [3:0] rx_e);
		for (int s = 0; s < 4; s++)
		begin
			apb(1'b1, OFS_CTRL, 32'h0000_8000 | (32'(s) << 2) | 32'(s));
			wt(3);
			chk({31'h0, tx_irq}, {31'h0, tx_e[s]});
			chk({31'h0, rx_irq}, {31'h0, rx_e[s]});
		end
	endtask : irq_tab
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	// cut a hang short
	initial
	begin
		#400000;
		err_count++;
		close_out();
	end
	initial
	begin
		wt(4);
		rstn <= 1'b1;
		rdc(OFS_CTRL, CTRL_RST);
		rdc(OFS_CTRL2, CTRL2_RST);
		rdc(OFS_STAT, 32'h0000_0014);
		apb(1'b1, OFS_CTRL, 32'h0000_4000);
		rdc(OFS_CTRL, 32'h0000_4000);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("end of test 1");
		apb(1'b1, OFS_CTRL, 32'h0000_0060);
		wt(10);
		chk({31'h0, sck_oe}, 32'h1);
		rdc(OFS_CTRL, 32'h0000_0060);
		apb(1'b1, OFS_CTRL, 32'h0000_8000);
		apb(1'b1, OFS_CTRL, 32'h0000_8060);
		apb(1'b1, OFS_CTRL2, 32'h0000_0080);
		rdc(OFS_CTRL, 32'h0000_8000);
		rdc(OFS_CTRL2, 32'h0);
		chk({31'h0, sck_oe}, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h0000_8010);
		wt(4);
		chk({31'h0, sdi_own}, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h0000_8000);
		wt(4);
		chk({31'h0, sdi_own}, 32'h1);
		$display("end of test 2");
		irq_tab(4'b1111, 4'b0000);
		apb(1'b1, OFS_DATA, {24'h0, tw[0]});
		rd = 32'h0;
		for (int n = 0; n < 40 && rd[STAT_BUSY] !== 1'b1; n++)
			apb(1'b0, OFS_STAT, 32'h0);
		chk({31'h0, rd[STAT_BUSY]}, 32'h1);
		irq_tab(4'b1110, 4'b0000);
		for (int i = 1; i < 3; i++)
			apb(1'b1, OFS_DATA, {24'h0, tw[i]});
		irq_tab(4'b1100, 4'b0000);
		for (int i = 3; i < 6; i++)
			apb(1'b1, OFS_DATA, {24'h0, tw[i]});
		rdc(OFS_STAT, 32'h0000_0413);
		irq_tab(4'b0000, 4'b0000);
		$display("end of test 3");
		for (int i = 0; i < 4; i++)
		begin
			u_partner.frame(pw[i]);
			wt(20);
			chk({24'h0, got}, {24'h0, tw[i]});
			if (i == 0)
				irq_tab(4'b1000, 4'b0010);
			if (i == 1)
				irq_tab(4'b1100, 4'b0110);
		end
		irq_tab(4'b1110, 4'b1110);
		for (int i = 0; i < 4; i++)
			rdc(OFS_DATA, {24'h0, pw[i]});
		irq_tab(4'b1110, 4'b0001);
		u_partner.frame(8'h00);
		wt(20);
		chk({24'h0, got}, {24'h0, tw[4]});
		$display("end of test 4");
		apb(1'b1, OFS_CTRL, 32'h0);
		wt(4);
		apb(1'b1, OFS_CTRL, 32'h0000_0020);
		wt(20);
		chk({30'h0, sck_oe, sck_o}, 32'h2);
		apb(1'b1, OFS_CTRL2, 32'h0000_0080);
		cpol <= 1'b1;
		wt(20);
		chk({30'h0, sck_oe, sck_o}, 32'h3);
		apb(1'b1, OFS_CTRL, 32'h0000_8020);
		wt(150);
		chk({24'h0, got}, 32'h0);
		rdc(OFS_DATA, 32'h0000_0000);
		rdc(OFS_DATA, 32'h0000_00FF);
		$display("end of test 5");
		close_out();
	end
endmodule : sbimc_top_tb
